/* uacp_chan_pair.v */
// Asynchronous serial channel pair: channel 0 sends, channel 1 receives.
`timescale 1ns/1ps
`include "uacp_defines.vh"

module uacp_chan_pair (
  // Clock and reset.
  input  wire        REF_CLK,
  input  wire        RST,
  // APB slave.
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Serial pins.
  input  wire        RXD,
  input  wire        SCK_IN,
  output reg         TXD,
  // Channel events.
  output reg         TX_IRQ,
  output reg         RX_IRQ,
  output reg         RX_ERR_IRQ
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA  = 3'd2;
  localparam ST_PAR   = 3'd3;
  localparam ST_STOP  = 3'd4;
  localparam ST_DONE  = 3'd5;

  reg  [15:0] smr0_r;
  reg  [15:0] smr1_r;
  reg  [15:0] scr0_r;
  reg  [15:0] scr1_r;
  reg  [6:0]  div0_r;
  reg  [6:0]  div1_r;
  reg  [7:0]  sps_r;
  reg  [7:0]  txbuf_r;
  reg         txbuf_full_r;
  reg         run0_r;
  reg         run1_r;
  reg         rx_swgo_r;
  reg  [14:0] presc_cnt_r;
  reg         sck_d_r;
  reg         rx_in_d_r;
  reg  [2:0]  tx_st_r;
  reg  [2:0]  tx_cnt_r;
  reg         tx_stop_r;
  reg  [7:0]  tx_data_r;
  reg  [2:0]  rx_st_r;
  reg  [2:0]  rx_cnt_r;
  reg  [7:0]  rx_sh_r;
  reg         rx_pbit_r;
  reg         rx_ferr_r;
  reg  [7:0]  rxbuf_r;
  reg         rx_full_r;
  reg         par_err_r;
  reg         frm_err_r;
  reg         ovr_err_r;
  reg  [31:0] rd_data;
  reg         rd_ok;

  wire        acc;
  wire        apb_wr;
  wire        apb_rd;
  wire        ctrl_wr;
  wire        rx_rd;
  wire        prescale_out_zero;
  wire        prescale_out_one;
  wire        mck0;
  wire        mck1;
  wire        sck_rise;
  wire        tx_div_tick;
  wire        rx_div_tick;
  wire        rx_mid;
  wire        tx_tick;
  wire        rx_smp;
  wire        tx_active;
  wire        rx_active;
  wire        tx_load;
  wire        rx_in;
  wire        start_edge;
  wire        rx_begin;
  wire        tx_irq_source_sel;
  wire        rx_irq_source_sel;
  wire        ch0_bit_order;
  wire        ch1_bit_order;
  wire        ch1_err_irq_allow;
  wire [1:0]  ptc0;
  wire [1:0]  ptc1;
  wire [1:0]  slc0;
  wire [1:0]  slc1;
  wire [2:0]  tx_last;
  wire [2:0]  rx_last;
  wire [2:0]  tx_ncnt;
  wire [2:0]  tx_idx;
  wire [2:0]  rx_idx;
  wire [7:0]  tx_dm;
  wire        tx_nbit;
  wire        tx_pbit;
  wire        rx_perr;

  // --------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------
  // Configuration fields that steer the two channels.
  assign tx_irq_source_sel = smr0_r[`UACP_MD_IRQ];
  assign rx_irq_source_sel = smr1_r[`UACP_MD_IRQ];
  assign ch0_bit_order     = scr0_r[`UACP_DIR];
  assign ch1_bit_order     = scr1_r[`UACP_DIR];
  assign ch1_err_irq_allow = scr1_r[`UACP_EOC];
  assign ptc0 = scr0_r[`UACP_PTC_HI:`UACP_PTC_LO];
  assign ptc1 = scr1_r[`UACP_PTC_HI:`UACP_PTC_LO];
  assign slc0 = scr0_r[`UACP_SLC_HI:`UACP_SLC_LO];
  assign slc1 = scr1_r[`UACP_SLC_HI:`UACP_SLC_LO];

  // Code 10 gives seven bits; 11 and the prohibited codes give eight.
  assign tx_last = (scr0_r[`UACP_DLS_HI:`UACP_DLS_LO] == `UACP_DLS_7BIT) ?
                   3'd6 : 3'd7;
  assign rx_last = (scr1_r[`UACP_DLS_HI:`UACP_DLS_LO] == `UACP_DLS_7BIT) ?
                   3'd6 : 3'd7;

  // Only the asynchronous mode frames data; the other codes idle.
  assign tx_active = run0_r & scr0_r[`UACP_TXE] &
    (smr0_r[`UACP_MD_HI:`UACP_MD_LO] == `UACP_MODE_UART);
  assign rx_active = run1_r & scr1_r[`UACP_RXE] &
    (smr1_r[`UACP_MD_HI:`UACP_MD_LO] == `UACP_MODE_UART);

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  assign acc     = PSEL & PENABLE;
  assign apb_wr  = acc & PREADY & PWRITE & ~PSLVERR;
  assign apb_rd  = acc & PREADY & ~PWRITE;
  assign ctrl_wr = apb_wr & (PADDR == `UACP_OFF_CTRL);
  assign rx_rd   = apb_rd & (PADDR == `UACP_OFF_RX_DATA);

  // Read multiplexer; any other address answers with an error.
  always @* begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (PADDR)
      `UACP_OFF_TX_MODE: rd_data = {16'h0000, smr0_r};
      `UACP_OFF_RX_MODE: rd_data = {16'h0000, smr1_r};
      `UACP_OFF_TX_COMM: rd_data = {16'h0000, scr0_r};
      `UACP_OFF_RX_COMM: rd_data = {16'h0000, scr1_r};
      `UACP_OFF_TX_DATA: rd_data = {16'h0000, div0_r, 1'b0, txbuf_r};
      `UACP_OFF_RX_DATA: rd_data = {16'h0000, div1_r, 1'b0, rxbuf_r};
      `UACP_OFF_PRESC:   rd_data = {24'h000000, sps_r};
      `UACP_OFF_CTRL:    rd_data = {22'h000000, run1_r, run0_r, 1'b0,
                                    ovr_err_r, frm_err_r, par_err_r,
                                    rx_full_r, (rx_st_r != ST_IDLE),
                                    txbuf_full_r, (tx_st_r != ST_IDLE)};
      default:           rd_ok   = 1'b0;
    endcase
  end

  // Every access gets one wait state; read data is latched with ready.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= acc & ~PREADY;
      PSLVERR <= acc & ~PREADY & ~rd_ok;
      if (acc & ~PREADY) begin
        PRDATA <= rd_data;
      end
    end
  end

  // Configuration registers, the transmit buffer and channel run bits.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      smr0_r       <= `UACP_RST_TX_MODE;
      smr1_r       <= `UACP_RST_RX_MODE;
      scr0_r       <= `UACP_RST_TX_COMM;
      scr1_r       <= `UACP_RST_RX_COMM;
      div0_r       <= `UACP_RST_DIV;
      div1_r       <= `UACP_RST_DIV;
      sps_r        <= `UACP_RST_PRESC;
      txbuf_r      <= 8'h00;
      txbuf_full_r <= 1'b0;
      run0_r       <= 1'b0;
      run1_r       <= 1'b0;
      rx_swgo_r    <= 1'b0;
    end else begin
      rx_swgo_r <= ctrl_wr & PWDATA[`UACP_CT_START1];
      if (tx_load) begin
        txbuf_full_r <= 1'b0;
      end
      if (apb_wr) begin
        case (PADDR)
          `UACP_OFF_TX_MODE: smr0_r <= (PWDATA[15:0] & `UACP_TXM_MASK) |
                                       `UACP_MODE_FIX;
          `UACP_OFF_RX_MODE: smr1_r <= (PWDATA[15:0] & `UACP_RXM_MASK) |
                                       `UACP_MODE_FIX;
          `UACP_OFF_TX_COMM: scr0_r <= (PWDATA[15:0] & `UACP_COMM_MASK) |
                                       `UACP_COMM_FIX;
          `UACP_OFF_RX_COMM: scr1_r <= (PWDATA[15:0] & `UACP_COMM_MASK) |
                                       `UACP_COMM_FIX;
          `UACP_OFF_TX_DATA: begin
            div0_r       <= PWDATA[`UACP_DIV_HI:`UACP_DIV_LO];
            txbuf_r      <= PWDATA[7:0];
            txbuf_full_r <= 1'b1;
          end
          `UACP_OFF_RX_DATA: div1_r <= PWDATA[`UACP_DIV_HI:`UACP_DIV_LO];
          `UACP_OFF_PRESC:   sps_r  <= PWDATA[7:0];
          `UACP_OFF_CTRL: begin
            if (PWDATA[`UACP_CT_START0]) run0_r <= 1'b1;
            if (PWDATA[`UACP_CT_START1]) run1_r <= 1'b1;
            if (PWDATA[`UACP_CT_STOP0])  run0_r <= 1'b0;
            if (PWDATA[`UACP_CT_STOP1])  run1_r <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Clock generation
  // --------------------------------------------------------------------
  // Free counter shared by both prescaler outputs; the clock pin is
  // delayed one cycle to find its rising edge.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      presc_cnt_r <= 15'h0000;
      sck_d_r     <= 1'b0;
      rx_in_d_r   <= 1'b1;
    end else begin
      presc_cnt_r <= presc_cnt_r + 15'h0001;
      sck_d_r     <= SCK_IN;
      rx_in_d_r   <= rx_in;
    end
  end

  uacp_presc u_presc0 (
    .clk (REF_CLK),
    .rst (RST),
    .cnt (presc_cnt_r),
    .sel (sps_r[3:0]),
    .en  (prescale_out_zero)
  );

  uacp_presc u_presc1 (
    .clk (REF_CLK),
    .rst (RST),
    .cnt (presc_cnt_r),
    .sel (sps_r[7:4]),
    .en  (prescale_out_one)
  );

  // Operation clock of each channel picks one prescaler output.
  assign mck0 = smr0_r[`UACP_CKS] ? prescale_out_one : prescale_out_zero;
  assign mck1 = smr1_r[`UACP_CKS] ? prescale_out_one :
                prescale_out_zero;
  assign sck_rise = SCK_IN & ~sck_d_r;

  uacp_bitclk u_txclk (
    .clk     (REF_CLK),
    .rst     (RST),
    .en      (mck0),
    .restart (tx_load),
    .div     (div0_r),
    .tick    (tx_div_tick),
    .mid     ()
  );

  uacp_bitclk u_rxclk (
    .clk     (REF_CLK),
    .rst     (RST),
    .en      (mck1),
    .restart (rx_begin),
    .div     (div1_r),
    .tick    (rx_div_tick),
    .mid     (rx_mid)
  );

  // Divided clock or the serial clock pin times each bit.
  assign tx_tick = smr0_r[`UACP_CCS] ? sck_rise : tx_div_tick;
  assign rx_smp  = smr1_r[`UACP_CCS] ? sck_rise : rx_mid;

  // --------------------------------------------------------------------
  // Transmit channel
  // --------------------------------------------------------------------
  // Next data bit in the chosen order and the parity bit to append.
  assign tx_ncnt = (tx_st_r == ST_START) ? 3'd0 : tx_cnt_r + 3'd1;
  assign tx_idx  = ch0_bit_order ? tx_ncnt : tx_last - tx_ncnt;
  assign tx_nbit = tx_data_r[tx_idx];
  assign tx_dm   = (tx_last == 3'd6) ? {1'b0, tx_data_r[6:0]} : tx_data_r;
  assign tx_pbit = (ptc0 == 2'b01) ? 1'b0 :
                   (ptc0 == 2'b10) ? ^tx_dm : ~^tx_dm;
  assign tx_load = tx_active & (tx_st_r == ST_IDLE) & txbuf_full_r;

  // Frame sequencer: start, data, optional parity, zero to two stops.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_st_r   <= ST_IDLE;
      tx_cnt_r  <= 3'd0;
      tx_stop_r <= 1'b0;
      tx_data_r <= 8'h00;
      TXD       <= 1'b1;
      TX_IRQ    <= 1'b0;
    end else begin
      TX_IRQ <= 1'b0;
      if (!tx_active) begin
        tx_st_r <= ST_IDLE;
        TXD     <= 1'b1;
      end else if (tx_load) begin
        tx_data_r <= txbuf_r;
        tx_st_r   <= ST_START;
        TXD       <= 1'b0;
        TX_IRQ    <= tx_irq_source_sel;
      end else if (tx_tick) begin
        case (tx_st_r)
          ST_START: begin
            TXD      <= tx_nbit;
            tx_cnt_r <= 3'd0;
            tx_st_r  <= ST_DATA;
          end
          ST_DATA: begin
            if (tx_cnt_r != tx_last) begin
              TXD      <= tx_nbit;
              tx_cnt_r <= tx_ncnt;
            end else if (ptc0 != 2'b00) begin
              TXD     <= tx_pbit;
              tx_st_r <= ST_PAR;
            end else if (slc0 != 2'b00) begin
              TXD       <= 1'b1;
              tx_stop_r <= 1'b0;
              tx_st_r   <= ST_STOP;
            end else begin
              TXD     <= 1'b1;
              tx_st_r <= ST_IDLE;
              TX_IRQ  <= ~tx_irq_source_sel;
            end
          end
          ST_PAR: begin
            TXD <= 1'b1;
            if (slc0 != 2'b00) begin
              tx_stop_r <= 1'b0;
              tx_st_r   <= ST_STOP;
            end else begin
              tx_st_r <= ST_IDLE;
              TX_IRQ  <= ~tx_irq_source_sel;
            end
          end
          ST_STOP: begin
            if ((slc0 == `UACP_SLC_TWO) && !tx_stop_r) begin
              tx_stop_r <= 1'b1;
            end else begin
              tx_st_r <= ST_IDLE;
              TX_IRQ  <= ~tx_irq_source_sel;
            end
          end
          default: tx_st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Receive channel
  // --------------------------------------------------------------------
  // Inversion makes a rising pin edge look like a falling start edge.
  assign rx_in      = RXD ^ smr1_r[`UACP_SIS];
  assign start_edge = rx_in_d_r & ~rx_in;
  // Software is expected to allow four clocks after enabling reception.
  assign rx_begin = rx_active & (rx_st_r == ST_IDLE) &
    (smr1_r[`UACP_STS] ? start_edge : rx_swgo_r);
  assign rx_idx  = ch1_bit_order ? rx_cnt_r : rx_last - rx_cnt_r;
  assign rx_perr = ((ptc1 == 2'b10) & (^{rx_sh_r, rx_pbit_r})) |
                   ((ptc1 == 2'b11) & ~(^{rx_sh_r, rx_pbit_r}));

  // Receive sequencer, data buffer and sticky error flags.
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rx_st_r    <= ST_IDLE;
      rx_cnt_r   <= 3'd0;
      rx_sh_r    <= 8'h00;
      rx_pbit_r  <= 1'b0;
      rx_ferr_r  <= 1'b0;
      rxbuf_r    <= 8'h00;
      rx_full_r  <= 1'b0;
      par_err_r  <= 1'b0;
      frm_err_r  <= 1'b0;
      ovr_err_r  <= 1'b0;
      RX_IRQ     <= 1'b0;
      RX_ERR_IRQ <= 1'b0;
    end else begin
      RX_IRQ     <= 1'b0;
      RX_ERR_IRQ <= 1'b0;
      if (rx_rd) begin
        rx_full_r <= 1'b0;
        RX_IRQ    <= rx_irq_source_sel;
      end
      if (ctrl_wr & PWDATA[`UACP_CT_CLRPAR]) par_err_r <= 1'b0;
      if (ctrl_wr & PWDATA[`UACP_CT_CLRFRM]) frm_err_r <= 1'b0;
      if (ctrl_wr & PWDATA[`UACP_CT_CLROVR]) ovr_err_r <= 1'b0;
      if (!rx_active) begin
        rx_st_r <= ST_IDLE;
      end else if (rx_begin) begin
        rx_st_r   <= ST_START;
        rx_sh_r   <= 8'h00;
        rx_ferr_r <= 1'b0;
        rx_pbit_r <= 1'b0;
      end else begin
        case (rx_st_r)
          ST_START: if (rx_smp) begin
            rx_cnt_r <= 3'd0;
            rx_st_r  <= rx_in ? ST_IDLE : ST_DATA;
          end
          ST_DATA: if (rx_smp) begin
            rx_sh_r[rx_idx] <= rx_in;
            rx_cnt_r        <= rx_cnt_r + 3'd1;
            if (rx_cnt_r != rx_last) begin
              rx_st_r <= ST_DATA;
            end else if (ptc1 != 2'b00) begin
              rx_st_r <= ST_PAR;
            end else if (slc1 != 2'b00) begin
              rx_st_r <= ST_STOP;
            end else begin
              rx_st_r <= ST_DONE;
            end
          end
          ST_PAR: if (rx_smp) begin
            rx_pbit_r <= rx_in;
            rx_st_r   <= (slc1 != 2'b00) ? ST_STOP : ST_DONE;
          end
          ST_STOP: if (rx_smp) begin
            rx_ferr_r <= ~rx_in;
            rx_st_r   <= ST_DONE;
          end
          ST_DONE: begin
            rxbuf_r   <= rx_sh_r;
            rx_full_r <= 1'b1;
            if (rx_full_r & ~rx_rd) ovr_err_r <= 1'b1;
            if (rx_perr) par_err_r <= 1'b1;
            if (rx_ferr_r) frm_err_r <= 1'b1;
            RX_IRQ     <= ~rx_irq_source_sel;
            RX_ERR_IRQ <= ch1_err_irq_allow &
                          (rx_perr | rx_ferr_r | (rx_full_r & ~rx_rd));
            rx_st_r    <= ST_IDLE;
          end
          default: rx_st_r <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

/* uacp_defines.vh */
// Register map, field positions and reset values of the channel pair.
`ifndef UACP_DEFINES_VH
`define UACP_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets on the APB bus
// ----------------------------------------------------------------------
`define UACP_OFF_TX_MODE  8'h00
`define UACP_OFF_RX_MODE  8'h04
`define UACP_OFF_TX_COMM  8'h08
`define UACP_OFF_RX_COMM  8'h0c
`define UACP_OFF_TX_DATA  8'h10
`define UACP_OFF_RX_DATA  8'h14
`define UACP_OFF_PRESC    8'h18
`define UACP_OFF_CTRL     8'h1c

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define UACP_CKS     15
`define UACP_CCS     14
`define UACP_STS     8
`define UACP_SIS     6
`define UACP_MD_HI   2
`define UACP_MD_LO   1
`define UACP_MD_IRQ  0
`define UACP_MODE_UART 2'b01
`define UACP_TXM_MASK  16'hc107
`define UACP_RXM_MASK  16'hc147
`define UACP_MODE_FIX  16'h0020

// ----------------------------------------------------------------------
// Communication register fields
// ----------------------------------------------------------------------
`define UACP_TXE     15
`define UACP_RXE     14
`define UACP_EOC     10
`define UACP_PTC_HI  9
`define UACP_PTC_LO  8
`define UACP_DIR     7
`define UACP_SLC_HI  5
`define UACP_SLC_LO  4
`define UACP_DLS_HI  1
`define UACP_DLS_LO  0
`define UACP_COMM_MASK 16'hf7b3
`define UACP_COMM_FIX  16'h0004
`define UACP_DLS_7BIT  2'b10
`define UACP_SLC_TWO   2'b10

// ----------------------------------------------------------------------
// Data register and control register fields
// ----------------------------------------------------------------------
`define UACP_DIV_HI  15
`define UACP_DIV_LO  9
`define UACP_CT_START0 0
`define UACP_CT_START1 1
`define UACP_CT_STOP0  2
`define UACP_CT_STOP1  3
`define UACP_CT_CLRPAR 4
`define UACP_CT_CLRFRM 5
`define UACP_CT_CLROVR 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UACP_RST_TX_MODE 16'h0022
`define UACP_RST_RX_MODE 16'h0122
`define UACP_RST_TX_COMM 16'h8297
`define UACP_RST_RX_COMM 16'h4697
`define UACP_RST_DIV     7'h40
`define UACP_RST_PRESC   8'h04

`endif

/* uacp_presc.v */
// One prescaler output: a clock enable at the reference rate over 2^sel.
`timescale 1ns/1ps

module uacp_presc (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst,
  // Shared free counter and divide selection.
  input  wire [14:0] cnt,
  input  wire [3:0]  sel,
  // Enable pulse.
  output reg         en
);

  wire [14:0] mask;

  // Low sel bits of the counter all ones marks one cycle in 2^sel.
  assign mask = ~(15'h7fff << sel);

  // The enable is registered; it is a one-cycle pulse except at sel zero, where it stays high.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en <= 1'b0;
    end else begin
      en <= &(cnt | ~mask);
    end
  end

endmodule

/* uacp_bitclk.v */
// Transfer clock divider giving a bit tick and a mid-bit sample pulse.
`timescale 1ns/1ps

module uacp_bitclk (
  // Clock and reset.
  input  wire       clk,
  input  wire       rst,
  // Operation clock enable and frame restart.
  input  wire       en,
  input  wire       restart,
  // Divider field: period is twice the field plus two, in enables.
  input  wire [6:0] div,
  // Bit end and bit middle pulses.
  output reg        tick,
  output reg        mid
);

  reg  [7:0] cnt_r;
  wire [7:0] last;

  // Last count of a bit period is 2*div+1.
  assign last = {div, 1'b1};

  // Count operation clock enables; a restart aligns the bit grid.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      tick  <= 1'b0;
      mid   <= 1'b0;
    end else begin
      tick <= 1'b0;
      mid  <= 1'b0;
      if (restart) begin
        cnt_r <= 8'h00;
      end else if (en) begin
        if (cnt_r == last) begin
          cnt_r <= 8'h00;
          tick  <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
        if (cnt_r == {1'b0, div}) begin
          mid <= 1'b1;
        end
      end
    end
  end

endmodule

/* uacp_chk_sva.sv */
// Checker for bus and event timing of the channel pair.
`timescale 1ns/1ps
module uacp_chk (
  // Clock and reset.
  input wire        REF_CLK,
  input wire        RST,
  // Bus.
  input wire        PSEL,
  input wire        PENABLE,
  input wire [7:0]  PADDR,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // Events.
  input wire        TX_IRQ,
  input wire        RX_ERR_IRQ
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  // Bus answers come one wait state after setup and last one cycle.
  AST_RDY_ONE: assert property (PREADY |=> !PREADY)
    else $error("Ready held too long.");
  AST_RDY_WAIT: assert property (
    (PSEL && !PENABLE ##1 PSEL && PENABLE) |=> PREADY)
    else $error("Ready late.");
  AST_BUS_ONLY: assert property (PREADY |-> PSEL && PENABLE)
    else $error("Ready outside access.");
  AST_ERR_MAP: assert property (PREADY |->
    PSLVERR == (PADDR > 8'h1c || PADDR[1:0] != 2'b00))
    else $error("Wrong error answer.");
  AST_ERR_DATA: assert property (
    PREADY && PSLVERR |-> PRDATA == 32'h0)
    else $error("Refused access returned data.");
  AST_UPPER: assert property (PRDATA[31:16] == 16'h0)
    else $error("Upper read data not zero.");
  // Channel events are single pulses.
  AST_TXI_ONE: assert property (TX_IRQ |=> !TX_IRQ)
    else $error("Transmit event too long.");
  AST_ERR_ONE: assert property (RX_ERR_IRQ |=> !RX_ERR_IRQ)
    else $error("Error event too long.");
  // Main scenarios reached.
  cover property (PREADY && PSLVERR);
  cover property (TX_IRQ);
  cover property (RX_ERR_IRQ);
endmodule

bind uacp_chan_pair uacp_chk uacp_chk_i (.REF_CLK(REF_CLK), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_IRQ(TX_IRQ),
  .RX_ERR_IRQ(RX_ERR_IRQ));

/* uacp_remote.sv */
// Remote serial device: sends on the receive line, samples transmit.
`timescale 1ns/1ps
module uacp_remote (
  // Clock.
  input  wire clk,
  // Serial lines.
  input  wire txd,
  output reg  rxd
);
  // The line idles high between frames.
  initial rxd = 1'b1;
  // Sends n bits, bit 0 first, each p clocks long.
  task send(input [10:0] f, input integer n, input integer p);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk);
        rxd <= f[i];
        repeat (p - 1) @(posedge clk);
      end
    end
  endtask
  // Waits for a start bit, then samples n bits in mid-bit.
  task grab(input integer n, input integer p, output reg [10:0] f,
            output reg ok);
    integer i;
    begin
      ok = 1'b0;
      f = 11'h7ff;
      for (i = 0; i < 3000 && !ok; i = i + 1) begin
        @(posedge clk);
        #1 ok = !txd;
      end
      repeat (p / 2) @(posedge clk);
      for (i = 0; i < n; i = i + 1) begin
        #1 f[i] = txd;
        repeat (p) @(posedge clk);
      end
    end
  endtask
endmodule

/* test_uart_channel_pair_config.sv */
// Self-checking bench for the serial channel pair.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared = n_compared + 1; \
  if ((a) !== (e)) begin fails = fails + 1; \
  $display("Error at %0t: got %h want %h", $time, a, e); end end
module test_uart_channel_pair_config;
  reg         REF_CLK, RST, PSEL, PENABLE, PWRITE, er, ok, SCK;
  reg  [7:0]  PADDR;
  reg  [31:0] PWDATA, rd;
  wire [31:0] PRDATA;
  wire        PREADY, PSLVERR, RXD, TXD, TX_IRQ, RX_IRQ, RX_ERR_IRQ;
  integer     fails, n_compared, n_tx, n_rx, n_err, i;
  reg  [10:0] f;
  reg  [47:0] rst_t [0:7];
  reg  [10:0] row_t [0:3];
  uacp_chan_pair uacp_chan_pair_i (.REF_CLK(REF_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RXD(RXD), .SCK_IN(SCK), .TXD(TXD), .TX_IRQ(TX_IRQ),
    .RX_IRQ(RX_IRQ), .RX_ERR_IRQ(RX_ERR_IRQ));
  uacp_remote uacp_remote_i (.clk(REF_CLK), .txd(TXD), .rxd(RXD));
  // Clock and event counters.
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    if (RST) begin
      n_tx <= 0;
      n_rx <= 0;
      n_err <= 0;
    end else begin
      n_tx <= n_tx + TX_IRQ;
      n_rx <= n_rx + RX_IRQ;
      n_err <= n_err + RX_ERR_IRQ;
    end
  end
  // Expected frame: start, data, parity, stop, idle high after.
  function [10:0] frm(input [7:0] d, input [1:0] pt, input dr);
    integer k;
    begin
      frm = 11'h7fe;
      for (k = 0; k < 8; k = k + 1) frm[k + 1] = dr ? d[k] : d[7 - k];
      if (pt != 2'b00) frm[9] = pt[1] & (pt[0] ^ (^d));
    end
  endfunction
  task stop_test;
    begin
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // One bus transfer; holds the request until ready is sampled.
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      k = 0;
      do begin
        @(posedge REF_CLK);
        k = k + 1;
      end while (PREADY !== 1'b1 && k < 20);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1) begin fails = fails + 1; stop_test; end
    end
  endtask
  task wait_rx(input integer t);
    integer k;
    begin
      for (k = 0; k < 400 && n_rx < t; k = k + 1) @(posedge REF_CLK);
      if (n_rx < t) begin fails = fails + 1; stop_test; end
    end
  endtask
  // Sends a frame and raises the clock pin in the middle of each bit.
  task sck_frame(input [10:0] fr);
    begin
      fork
        uacp_remote_i.send(fr, 11, 16);
        repeat (11) begin
          repeat (8) @(posedge REF_CLK);
          SCK <= 1'b1;
          repeat (8) @(posedge REF_CLK);
          SCK <= 1'b0;
        end
      join
    end
  endtask
  initial begin
    rst_t[0] = {8'h00, 32'h0022, 8'h0};
    rst_t[1] = {8'h04, 32'h0122, 8'h0};
    rst_t[2] = {8'h08, 32'h8297, 8'h0};
    rst_t[3] = {8'h0c, 32'h4697, 8'h0};
    rst_t[4] = {8'h14, 32'h8000, 8'h0};
    rst_t[5] = {8'h18, 32'h0004, 8'h0};
    rst_t[6] = {8'h22, 32'h0000, 8'h1};
    rst_t[7] = {8'h20, 32'h0000, 8'h1};
    row_t[0] = {2'b00, 1'b0, 8'h41};
    row_t[1] = {2'b01, 1'b1, 8'h80};
    row_t[2] = {2'b10, 1'b0, 8'hc3};
    row_t[3] = {2'b11, 1'b1, 8'h7e};
    {fails, n_compared} = 0;
    {SCK, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 0;
    RST = 1'b1;
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b0, rst_t[i][47:40], 32'h0);
      `CHK(rd, rst_t[i][39:8])
      `CHK(er, rst_t[i][0])
    end
    $display("Reset and map test done.");
    // Receive channel runs from the halved prescaler output.
    apb(1'b1, 8'h18, 32'h10);
    apb(1'b1, 8'h04, 32'h8122);
    apb(1'b1, 8'h14, 32'h0600);
    apb(1'b1, 8'h1c, 32'h3);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 8'h08, 32'h8017 | (row_t[i][10:8] << 7));
      apb(1'b1, 8'h0c, 32'h4417 | (row_t[i][10:8] << 7));
      fork
        apb(1'b1, 8'h10, 32'h0600 | row_t[i][7:0]);
        uacp_remote_i.grab(11, 8, f, ok);
      join
      `CHK(ok, 1'b1)
      `CHK(f, frm(row_t[i][7:0], row_t[i][10:9], row_t[i][8]))
      `CHK(n_tx, i + 1)
      uacp_remote_i.send(frm(row_t[i][7:0], row_t[i][10:9], row_t[i][8]),
        11, 16);
      wait_rx(i + 1);
      apb(1'b0, 8'h14, 32'h0);
      `CHK(rd[7:0], row_t[i][7:0])
    end
    `CHK(n_err, 0)
    $display("Frame table done.");
    // Bad parity: reported when allowed, silent when masked.
    apb(1'b1, 8'h0c, 32'h4697);
    uacp_remote_i.send(frm(8'h5a, 2'b10, 1'b1) ^ 11'h200, 11, 16);
    wait_rx(5);
    `CHK(n_err, 1)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK(rd[4], 1'b1)
    apb(1'b1, 8'h0c, 32'h4297);
    uacp_remote_i.send(frm(8'h5a, 2'b10, 1'b1) ^ 11'h200, 11, 16);
    wait_rx(6);
    `CHK(n_err, 1)
    $display("Parity error test done.");
    // Clock pin timing with a divider that would sample far too fast.
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h04, 32'hc022);
    sck_frame(frm(8'h3c, 2'b10, 1'b1));
    `CHK(n_rx, 6)
    apb(1'b1, 8'h04, 32'hc122);
    sck_frame(frm(8'h3c, 2'b10, 1'b1));
    wait_rx(7);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd[7:0], 8'h3c)
    apb(1'b1, 8'h04, 32'h8123);
    apb(1'b0, 8'h14, 32'h0);
    repeat (2) @(posedge REF_CLK);
    `CHK(n_rx, 8)
    $display("Clock pin and start test done.");
    stop_test;
  end
endmodule
